// [rtl/scflr_pkg.sv]
// shared constants of the serial-port configuration and table-step register bank
// assumes one system clock; referenced by the sequencer and register bank files
package scflr_pkg;
	// =====================================================
	// register offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CFG_A = 8'h00;
	localparam logic [7:0] OFS_CFG_B = 8'h01;
	localparam logic [7:0] OFS_CHIP_TYPE = 8'h03;
	localparam logic [7:0] OFS_PROD_LOW = 8'h04;
	localparam logic [7:0] OFS_PROD_HIGH = 8'h05;
	localparam logic [7:0] OFS_REVISION = 8'h0C;
	localparam logic [7:0] OFS_END_IDX = 8'h11;
	localparam logic [7:0] OFS_BEGIN_IDX = 8'h12;
	localparam logic [7:0] OFS_STEP_DIR = 8'h13;
	localparam logic [7:0] OFS_SEQ_STATE = 8'h14;

	// =====================================================
	// field positions
	localparam int CFGB_SINGLE_BIT = 7;
	localparam int CFGB_STALL_BIT = 6;
	localparam int CFGB_SHADOW_BIT = 5;
	localparam int CFGB_XFER_BIT = 0;
	localparam int IDX_W = 7;

	// =====================================================
	// values after reset
	localparam logic [3:0] RST_CFG_A = 4'h0;
	localparam logic [7:0] RST_CFG_B = 8'h00;
	localparam logic [6:0] RST_END_IDX = 7'h7F;
	localparam logic [6:0] RST_BEGIN_IDX = 7'h00;
	localparam logic RST_STEP_DIR = 1'b0;
	localparam logic [2:0] RST_CS_SYNC = 3'h7;
endpackage

// [rtl/scflr_seq_if.sv]
// signals between the register bank and the table-step sequencer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface scflr_seq_if;
	logic [6:0] beginIdx;
	logic [6:0] endIdx;
	logic dirDown;
	logic reload;
	logic step;
	logic [6:0] index;
	modport ctrl (output beginIdx, output endIdx, output dirDown, output reload,
		output step, input index);
	modport seq (input beginIdx, input endIdx, input dirDown, input reload,
		input step, output index);
endinterface
`default_nettype wire

// [rtl/scflr_sequencer.sv]
// table-step sequencer: holds the next table location and steps it
// assumes reload and step are single-cycle strobes on clk_sys
`timescale 1ns/1ps
`default_nettype none
module scflr_sequencer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// link to the register bank
	scflr_seq_if.seq sq
);
	logic [6:0] index;
	logic [6:0] next_index;

	// =====================================================
	// next index: reload wins over a step
	always_comb
	begin
		next_index = index;
		if (sq.reload)
		begin
			next_index = sq.dirDown ? sq.endIdx : sq.beginIdx;
		end
		else if (sq.step)
		begin
			// wrap back to the origin once the far end is reached
			if (!sq.dirDown)
				next_index = (index == sq.endIdx) ? sq.beginIdx : index + 7'h01;
			else
				next_index = (index == sq.beginIdx) ? sq.endIdx : index - 7'h01;
		end
	end

	// index register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			index <= scflr_pkg::RST_BEGIN_IDX;
		else if (ce)
			index <= next_index;
	end

	assign sq.index = index;

	// =====================================================
	// checks
	a_load_begin_up: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && sq.reload && !sq.dirDown) |=> index == $past(sq.beginIdx))
		else $error("index not loaded with begin index");
	a_load_end_down: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && sq.reload && sq.dirDown) |=> index == $past(sq.endIdx))
		else $error("index not loaded with end index");
	a_step_up_one: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && sq.step && !sq.reload && !sq.dirDown && index != sq.endIdx)
		|=> index == 7'($past(index) + 7'h01))
		else $error("increment step not by one");
	a_step_down_wrap: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && sq.step && !sq.reload && sq.dirDown && index == sq.beginIdx)
		|=> index == $past(sq.endIdx))
		else $error("decrement did not wrap to end index");
endmodule
`default_nettype wire

// [rtl/scflr_regs.sv]
// serial-port configuration, identity and table-step register bank
// assumes a serial front end that turns each frame byte into a one-cycle
// register strobe on clk_sys; chip_select_n arrives straight from the pin
//
// Summary of operation
// - config byte A holds four mirrored control pairs
// - config B bit 7 one disables streaming
// - chip type code is read only
// - product code low byte then high byte
// - end index seven bits, reset 0x7F
// - begin index seven bits, reset zero
// - direction bit: zero up, one down
// - going up, index loads begin index
// - going down, index loads end index
// - state register shows the next table location
// - index reloads when begin, end, direction written
`timescale 1ns/1ps
`default_nettype none
module scflr_regs #(
	parameter logic [7:0] CHIP_TYPE = 8'h07, // arbitrary value
	parameter logic [15:0] PRODUCT_CODE = 16'h5A3C, // arbitrary value
	parameter logic [3:0] REVISION = 4'h2 // arbitrary value
) (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// register strobes from the serial front end
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	output logic regRvalid,
	// pins and mode
	input wire logic chip_select_n,
	input wire logic tableStepMode,
	// configuration outputs
	output logic lsbFirst,
	output logic bigEndian,
	output logic serial_out_enable,
	output logic singleTransfer,
	output logic select_stall_ctrl,
	output logic shadow_readback_select,
	// table stepping
	output logic [6:0] tableIndex,
	output logic [6:0] appliedIndex,
	output logic tableApply
);
	scflr_seq_if sqIf ();

	logic [3:0] cfgA; // {serial out, endian, lsb first, soft reset}
	logic [7:0] cfgB;
	logic [6:0] endIdx;
	logic [6:0] beginIdx;
	logic stepDir;
	logic reload;
	logic [3:0] next_cfgA;
	logic [7:0] next_cfgB;
	logic [6:0] next_endIdx;
	logic [6:0] next_beginIdx;
	logic next_stepDir;
	logic next_reload;
	logic [7:0] next_regRdata;
	logic software_reset_bit;

	// =====================================================
	// register writes; a soft reset returns config A and B, begin, end and direction to reset values
	assign software_reset_bit = regWrite && regAddr == scflr_pkg::OFS_CFG_A
		&& (regWdata[7] || regWdata[0]);
	always_comb
	begin
		next_cfgA = cfgA;
		next_cfgB = cfgB;
		next_endIdx = endIdx;
		next_beginIdx = beginIdx;
		next_stepDir = stepDir;
		next_reload = 1'b0;
		if (software_reset_bit)
		begin
			next_cfgA = scflr_pkg::RST_CFG_A;
			next_cfgB = scflr_pkg::RST_CFG_B;
			next_endIdx = scflr_pkg::RST_END_IDX;
			next_beginIdx = scflr_pkg::RST_BEGIN_IDX;
			next_stepDir = scflr_pkg::RST_STEP_DIR;
			next_reload = 1'b1;
		end
		else if (regWrite)
		begin
			case (regAddr)
				// either half of a mirrored pair sets the control
				scflr_pkg::OFS_CFG_A: next_cfgA = {regWdata[4] | regWdata[3],
					regWdata[5] | regWdata[2], regWdata[6] | regWdata[1], 1'b0};
				scflr_pkg::OFS_CFG_B: next_cfgB = regWdata & 8'hE1;
				scflr_pkg::OFS_END_IDX:
				begin
					next_endIdx = regWdata[6:0];
					next_reload = 1'b1;
				end
				scflr_pkg::OFS_BEGIN_IDX:
				begin
					next_beginIdx = regWdata[6:0];
					next_reload = 1'b1;
				end
				scflr_pkg::OFS_STEP_DIR:
				begin
					next_stepDir = regWdata[0];
					next_reload = 1'b1;
				end
				default: ; // identity and state registers ignore writes
			endcase
		end
	end

	// control registers
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cfgA <= scflr_pkg::RST_CFG_A;
			cfgB <= scflr_pkg::RST_CFG_B;
			endIdx <= scflr_pkg::RST_END_IDX;
			beginIdx <= scflr_pkg::RST_BEGIN_IDX;
			stepDir <= scflr_pkg::RST_STEP_DIR;
			reload <= 1'b0;
		end
		else if (ce)
		begin
			cfgA <= next_cfgA;
			cfgB <= next_cfgB;
			endIdx <= next_endIdx;
			beginIdx <= next_beginIdx;
			stepDir <= next_stepDir;
			reload <= next_reload;
		end
	end

	// =====================================================
	// read path, answer one cycle after the strobe
	always_comb
	begin
		next_regRdata = 8'h00;
		if (regRead)
		begin
			case (regAddr)
				scflr_pkg::OFS_CFG_A: next_regRdata = {cfgA[0], cfgA[1], cfgA[2], cfgA[3],
					cfgA[3], cfgA[2], cfgA[1], cfgA[0]};
				scflr_pkg::OFS_CFG_B: next_regRdata = cfgB;
				scflr_pkg::OFS_CHIP_TYPE: next_regRdata = CHIP_TYPE;
				scflr_pkg::OFS_PROD_LOW: next_regRdata = PRODUCT_CODE[7:0];
				scflr_pkg::OFS_PROD_HIGH: next_regRdata = PRODUCT_CODE[15:8];
				scflr_pkg::OFS_REVISION: next_regRdata = {4'h0, REVISION};
				scflr_pkg::OFS_END_IDX: next_regRdata = {1'b0, endIdx};
				scflr_pkg::OFS_BEGIN_IDX: next_regRdata = {1'b0, beginIdx};
				scflr_pkg::OFS_STEP_DIR: next_regRdata = {7'h00, stepDir};
				scflr_pkg::OFS_SEQ_STATE: next_regRdata = {1'b0, sqIf.index};
				default: next_regRdata = 8'h00; // unmapped reads as zero
			endcase
		end
	end

	// read data registers
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			regRdata <= 8'h00;
			regRvalid <= 1'b0;
		end
		else if (ce)
		begin
			regRdata <= next_regRdata;
			regRvalid <= regRead;
		end
	end

	// =====================================================
	// chip select synchroniser; a level counts once stages two and three agree
	logic [2:0] csSync;
	logic csLevel;
	logic next_csLevel;
	logic csRise;
	logic [6:0] next_appliedIndex;
	logic next_tableApply;
	always_comb
	begin
		next_csLevel = (csSync[1] == csSync[2]) ? csSync[2] : csLevel;
		csRise = csSync[1] && csSync[2] && !csLevel;
		next_appliedIndex = csRise && tableStepMode ? sqIf.index : appliedIndex;
		next_tableApply = csRise && tableStepMode;
	end

	// synchroniser and table apply registers
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			csSync <= scflr_pkg::RST_CS_SYNC;
			csLevel <= 1'b1;
			appliedIndex <= 7'h00;
			tableApply <= 1'b0;
		end
		else if (ce)
		begin
			csSync <= {csSync[1:0], chip_select_n};
			csLevel <= next_csLevel;
			appliedIndex <= next_appliedIndex;
			tableApply <= next_tableApply;
		end
	end

	// =====================================================
	// sequencer hookup
	assign sqIf.beginIdx = beginIdx;
	assign sqIf.endIdx = endIdx;
	assign sqIf.dirDown = stepDir;
	assign sqIf.reload = reload;
	assign sqIf.step = csRise && tableStepMode && !reload;

	scflr_sequencer uSeq (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.sq(sqIf.seq)
	);

	// outputs straight from registers
	assign lsbFirst = cfgA[1];
	assign bigEndian = cfgA[2];
	assign serial_out_enable = cfgA[3];
	assign singleTransfer = cfgB[scflr_pkg::CFGB_SINGLE_BIT];
	assign select_stall_ctrl = cfgB[scflr_pkg::CFGB_STALL_BIT];
	assign shadow_readback_select = cfgB[scflr_pkg::CFGB_SHADOW_BIT];
	assign tableIndex = sqIf.index;

	// =====================================================
	// checks
	a_cfga_mirror: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && regRead && regAddr == scflr_pkg::OFS_CFG_A)
		|=> regRdata[7:4] == {regRdata[0], regRdata[1], regRdata[2], regRdata[3]}
		&& !regRdata[0])
		else $error("config A not mirrored");
	a_stream_ctrl: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && regWrite && !software_reset_bit && regAddr == scflr_pkg::OFS_CFG_B)
		|=> singleTransfer == $past(regWdata[7]))
		else $error("single transfer bit not taken");
	a_chip_type_ro: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && regRead && regAddr == scflr_pkg::OFS_CHIP_TYPE) |=> regRdata == CHIP_TYPE)
		else $error("chip type changed");
	a_product_high: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && regRead && regAddr == scflr_pkg::OFS_PROD_HIGH)
		|=> regRdata == PRODUCT_CODE[15:8])
		else $error("product high byte wrong");
	a_end_reserved: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && regRead && regAddr == scflr_pkg::OFS_END_IDX) |=> !regRdata[7])
		else $error("end index top bit set");
	a_begin_write: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && regWrite && regAddr == scflr_pkg::OFS_BEGIN_IDX)
		|=> beginIdx == $past(regWdata[6:0]))
		else $error("begin index not written");
	a_state_read: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && regRead && regAddr == scflr_pkg::OFS_SEQ_STATE)
		|=> regRdata == {1'b0, $past(tableIndex)})
		else $error("state read wrong");
	a_begin_reload: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && regWrite && regAddr == scflr_pkg::OFS_BEGIN_IDX && !stepDir)
		##1 (ce && !regWrite) |=> tableIndex == $past(regWdata[6:0], 2))
		else $error("index not reloaded after begin write");
endmodule
`default_nettype wire

// [test/scflr_host_model.sv]
// host model: register strobes and the select pin of the bank
// assumes the bench calls one task at a time on clk_sys
`timescale 1ns/1ps
`default_nettype none
module scflr_host_model (
	// clock
	input wire logic clk_sys,
	// register strobes
	output logic regWrite,
	output logic regRead,
	output logic [7:0] regAddr,
	output logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic regRvalid,
	// select pin
	output logic chip_select_n
);
	// =====================================================
	// idle levels at time zero
	initial
	begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
		chip_select_n = 1'b1;
	end
	// one write strobe; released lines carry the inverse
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) #1;
		regWrite = 1'b1;
		regAddr = a;
		regWdata = d;
		@(posedge clk_sys) #1;
		regWrite = 1'b0;
		regAddr = ~a;
		regWdata = ~d;
	endtask
	// one read strobe; answer taken one cycle later, as the strobe drops
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_sys) #1;
		regRead = 1'b1;
		regAddr = a;
		@(posedge clk_sys) #1;
		regRead = 1'b0;
		regAddr = ~a;
		d = regRdata;
		v = regRvalid;
	endtask
	// select low then high, both past the synchroniser depth
	task automatic pulse();
		@(posedge clk_sys) #1;
		chip_select_n = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		chip_select_n = 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
	endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// testbench of the configuration and table-step register bank
// assumes the host model drives all strobes and the select pin
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [15:0] PCODE = 16'h5A3C; // arbitrary value
	logic clk_sys, rst, ce, tableStepMode, regWrite, regRead, regRvalid, chip_select_n;
	logic [7:0] regAddr, regWdata, regRdata;
	logic lsbFirst, bigEndian, serial_out_enable, singleTransfer, select_stall_ctrl;
	logic shadow_readback_select, tableApply;
	logic [6:0] tableIndex, appliedIndex;
	int err_total = 0;
	int num_checks = 0;
	int applies = 0;
	// =====================================================
	// instances
	scflr_regs #(.CHIP_TYPE(8'h07), .PRODUCT_CODE(PCODE), .REVISION(4'h2)) scflr_regs_inst (
		.clk_sys(clk_sys), .rst(rst), .ce(ce), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
		.chip_select_n(chip_select_n), .tableStepMode(tableStepMode), .lsbFirst(lsbFirst),
		.bigEndian(bigEndian), .serial_out_enable(serial_out_enable),
		.singleTransfer(singleTransfer), .select_stall_ctrl(select_stall_ctrl),
		.shadow_readback_select(shadow_readback_select), .tableIndex(tableIndex),
		.appliedIndex(appliedIndex), .tableApply(tableApply));
	scflr_host_model scflr_host_model_inst (.clk_sys(clk_sys), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
		.regRvalid(regRvalid), .chip_select_n(chip_select_n));
	// clock and applied-entry counter
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
		if (tableApply === 1'b1)
			applies++;
	// =====================================================
	// helpers
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic v;
		scflr_host_model_inst.rd(a, d, v);
		chk({7'h00, v}, 8'h01);
		chk(d, exp);
	endtask
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// =====================================================
	// scenarios
	task automatic t_ident();
		rdchk(8'h00, 8'h00);
		rdchk(8'h11, 8'h7F);
		rdchk(8'h14, 8'h00);
		rdchk(8'h03, 8'h07);
		scflr_host_model_inst.wr(8'h03, 8'hF0);
		rdchk(8'h03, 8'h07);
		rdchk(8'h04, PCODE[7:0]);
		rdchk(8'h05, PCODE[15:8]);
		rdchk(8'h0C, 8'h02);
		rdchk(8'h40, 8'h00);
		$display("test ident done");
	endtask
	task automatic t_cfg();
		logic [2:0] e;
		for (int b = 1; b < 7; b++)
		begin
			scflr_host_model_inst.wr(8'h00, 8'h01 << b);
			e = (b == 1 || b == 6) ? 3'b100 : ((b == 2 || b == 5) ? 3'b010 : 3'b001);
			chk({5'h00, lsbFirst, bigEndian, serial_out_enable}, {5'h00, e});
		end
		scflr_host_model_inst.wr(8'h12, 8'h85);
		rdchk(8'h12, 8'h05);
		scflr_host_model_inst.wr(8'h11, 8'h8A);
		rdchk(8'h11, 8'h0A);
		scflr_host_model_inst.wr(8'h01, 8'hFF);
		rdchk(8'h01, 8'hE1);
		chk({5'h00, singleTransfer, select_stall_ctrl, shadow_readback_select}, 8'h07);
		scflr_host_model_inst.wr(8'h00, 8'h01);
		settle();
		chk({5'h00, singleTransfer, lsbFirst, bigEndian}, 8'h00);
		rdchk(8'h12, 8'h00);
		rdchk(8'h11, 8'h7F);
		$display("test config done");
	endtask
	task automatic t_step();
		logic [6:0] ex [4];
		ex = '{7'h05, 7'h06, 7'h07, 7'h05};
		tableStepMode = 1'b1;
		scflr_host_model_inst.wr(8'h12, 8'h05);
		scflr_host_model_inst.wr(8'h11, 8'h07);
		settle();
		chk({1'b0, tableIndex}, 8'h05);
		rdchk(8'h14, 8'h05);
		for (int i = 0; i < 3; i++)
		begin
			scflr_host_model_inst.pulse();
			chk({1'b0, appliedIndex}, {1'b0, ex[i]});
			chk({1'b0, tableIndex}, {1'b0, ex[i + 1]});
		end
		chk(applies[7:0], 8'h03);
		tableStepMode = 1'b0;
		scflr_host_model_inst.pulse();
		chk({1'b0, tableIndex}, 8'h05);
		chk(applies[7:0], 8'h03);
		tableStepMode = 1'b1;
		scflr_host_model_inst.wr(8'h13, 8'hFF);
		rdchk(8'h13, 8'h01);
		settle();
		chk({1'b0, tableIndex}, 8'h07);
		scflr_host_model_inst.pulse();
		chk({1'b0, tableIndex}, 8'h06);
		scflr_host_model_inst.pulse();
		chk({1'b0, tableIndex}, 8'h05);
		// stepping down from the begin index wraps to the end index
		scflr_host_model_inst.pulse();
		chk({1'b0, appliedIndex}, 8'h05);
		chk({1'b0, tableIndex}, 8'h07);
		scflr_host_model_inst.wr(8'h11, 8'h09);
		settle();
		chk({1'b0, tableIndex}, 8'h09);
		$display("test step done");
	endtask
	// frozen clock enable: a write strobe and a select pulse leave no trace
	task automatic t_hold();
		ce = 1'b0;
		scflr_host_model_inst.wr(8'h12, 8'h33);
		scflr_host_model_inst.pulse();
		ce = 1'b1;
		settle();
		chk({1'b0, tableIndex}, 8'h09);
		chk(applies[7:0], 8'h06);
		rdchk(8'h12, 8'h05);
		$display("test hold done");
	endtask
	// =====================================================
	// main sequence and watchdog
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		tableStepMode = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		t_ident();
		t_cfg();
		t_step();
		t_hold();
		summarize();
	end
	initial
	begin
		#50000;
		err_total++;
		summarize();
	end
endmodule
`default_nettype wire
